// File: hw/sra_fifo.sv
/*
 * Small flip-flop FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-low reset.
 */
`default_nettype none

module sra_fifo
    import sra_pkg::*;
#(
    parameter int WIDTH = 15,
    parameter int DEPTH = 4
)
(
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];    // Storage words
    logic [PW-1:0]    wr_q;             // Write index
    logic [PW-1:0]    rd_q;             // Read index
    logic [PW:0]      cnt_q;            // Occupancy
    wire              push;
    wire              pop;

    assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rd_q];

    // Indices wrap at DEPTH so non-power-of-two depths also work
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                mem_q[wr_q] <= in_data;
                wr_q        <= (wr_q == PW'(DEPTH-1)) ? '0 : PW'(wr_q + 1'b1);
            end
            if (pop)
                rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : PW'(rd_q + 1'b1);
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    property p_no_overfill;
        (cnt_q == (PW+1)'(DEPTH)) |-> !push;
    endproperty
    a_no_overfill: assert property (p_no_overfill) else $error("FIFO written when full");

endmodule // sra_fifo

`default_nettype wire

// File: hw/sra_slave.sv
/*
 * Serial register access slave: 128 byte registers written and read over
 * a select/clock/data-in/data-out port, with address auto-increment burst.
 * Assumes the link pins are asynchronous to clk_sys and the serial clock is
 * slow enough (bench: 400 ns period) for clk_sys to see both of its levels.
 */
`include "sra_defines.svh"
`default_nettype none

module sra_slave
    import sra_pkg::*;
#(
    parameter int FIFO_DEPTH = `SRA_FIFO_DEPTH
)
(
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic shutdown,        // High holds the block powered off
    input  wire logic sclk,            // Serial clock from the host
    input  wire logic select_n,        // Frame select, active low
    input  wire logic serial_in,       // Host data in
    output logic      serial_out,      // Read data out
    output logic      serial_out_oe,   // High while driving serial_out
    output logic      wr_drop          // Pulse: write byte lost, buffer full
);
    localparam int AW = `SRA_ADDR_W;
    localparam int DW = `SRA_DATA_W;
    localparam int FW = AW + DW;

    // Two-flop synchronisers; stage 3 only serves edge detection
    logic [2:0] sclk_q;
    logic [1:0] sel_q;
    logic [1:0] sin_q;
    logic [1:0] sdn_q;

    sra_state_t  st_q;                          // Frame state
    logic [2:0]  bit_q;                         // Bit within byte
    logic [7:0]  rx_q;                          // Input shifter
    logic        dir_q;                         // Captured direction
    logic [AW-1:0] addr_q;                      // Current register
    logic [DW-1:0] tx_q;                        // Output shifter
    logic [3:0]  left_q;                        // Bits still to send
    logic [DW-1:0] regs_q [`SRA_REG_COUNT];     // Register space
    logic        serial_out_q;
    logic        serial_out_oe_q;
    logic        wr_drop_q;

    // Decoded events
    wire rise    = sclk_q[1] && !sclk_q[2];
    wire fall    = !sclk_q[1] && sclk_q[2];
    wire sel_on  = !sel_q[1] && !sdn_q[1];
    wire sin_s   = sin_q[1];
    wire sdn_s   = sdn_q[1];
    wire [7:0] rx_next   = {rx_q[6:0], sin_s};
    wire byte_end        = rise && (bit_q == `SRA_BIT_LAST);
    wire hdr_end         = (st_q == SRA_ST_HDR) && byte_end;
    wire data_end        = (st_q == SRA_ST_DATA) && byte_end;
    wire hdr_write       = rx_next[`SRA_HDR_DIR_POS] == `SRA_DIR_WRITE;
    wire wr_byte         = data_end && (dir_q == `SRA_DIR_WRITE);
    wire [AW-1:0] addr_inc = AW'(addr_q + 1'b1);
    wire [AW-1:0] fetch_addr = hdr_end ? rx_next[AW-1:0] : addr_inc;
    wire load_rd = (hdr_end && !hdr_write) || (data_end && !dir_q);
    wire shift_out = fall && (left_q != 4'h0) && sel_on;

    // Write buffer between the frame logic and the register space
    wire          f_in_ready;
    wire          f_out_valid;
    wire [FW-1:0] f_out_data;
    // Drain stalls on a read fetch so the single register port is not shared
    wire          f_out_ready = !load_rd && !sdn_s;
    wire          pop = f_out_valid && f_out_ready;

    sra_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_wbuf
    (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .in_valid  (wr_byte),
        .in_ready  (f_in_ready),
        .in_data   ({addr_q, rx_next}),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );

    assign serial_out    = serial_out_q;
    assign serial_out_oe = serial_out_oe_q;
    assign wr_drop       = wr_drop_q;

    // Synchronise every pin into clk_sys
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            sclk_q <= 3'h0;
            sel_q  <= 2'h3;
            sin_q  <= 2'h0;
            sdn_q  <= 2'h0;
        end
        else
        begin
            sclk_q <= {sclk_q[1:0], sclk};
            sel_q  <= {sel_q[0], select_n};
            sin_q  <= {sin_q[0], serial_in};
            sdn_q  <= {sdn_q[0], shutdown};
        end
    end

    // Frame sequencer: header byte, then data bytes until select rises
    always_ff @(posedge clk_sys)
    begin
        if (!resetn || !sel_on)
        begin
            st_q  <= SRA_ST_IDLE;
            bit_q <= 3'h0;
            rx_q  <= 8'h00;
            dir_q <= 1'b0;
            addr_q <= '0;
        end
        else
        begin
            case (st_q)
                SRA_ST_IDLE:
                    st_q <= SRA_ST_HDR;
                SRA_ST_HDR:
                    if (hdr_end)
                    begin
                        st_q   <= SRA_ST_DATA;
                        dir_q  <= rx_next[`SRA_HDR_DIR_POS];
                        addr_q <= rx_next[AW-1:0];
                    end
                SRA_ST_DATA:
                    if (data_end)
                        addr_q <= addr_inc;
                default:
                    st_q <= SRA_ST_IDLE;
            endcase
            if (rise && st_q != SRA_ST_IDLE)
            begin
                bit_q <= 3'(bit_q + 1'b1);
                rx_q  <= rx_next;
            end
        end
    end

    // Read shifter: fetch on the last rising edge, send on falling edges.
    // A host that parks the clock low adds a fall after the last rise, which
    // already sends the next register's top bit; parked high, D0 stays put.
    always_ff @(posedge clk_sys)
    begin
        if (!resetn || !sel_on)
        begin
            tx_q            <= 8'h00;
            left_q          <= 4'h0;
            serial_out_q    <= 1'b1;
            serial_out_oe_q <= 1'b0;
        end
        else
        begin
            serial_out_oe_q <= 1'b1;
            if (load_rd)
            begin
                tx_q   <= regs_q[fetch_addr];
                left_q <= 4'h8;
            end
            else if (shift_out)
            begin
                serial_out_q <= tx_q[7];
                tx_q         <= {tx_q[6:0], 1'b0};
                left_q       <= 4'(left_q - 1'b1);
            end
            // Otherwise the last bit sent, D0, is held
        end
    end

    // Register space; a write that is still buffered is not seen by a read
    // fetched in the same cycle, which the host cannot cause at 10 MHz
    always_ff @(posedge clk_sys)
    begin
        if (!resetn || sdn_s)
        begin
            for (int i = 0; i < `SRA_REG_COUNT; i++)
                regs_q[i] <= `SRA_REG_RESET;
        end
        else if (pop)
            regs_q[f_out_data[FW-1:DW]] <= f_out_data[DW-1:0];
    end

    // Lost write report
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            wr_drop_q <= 1'b0;
        else
            wr_drop_q <= wr_byte && !f_in_ready;
    end

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence s_hdr_read;
        hdr_end && !hdr_write && sel_on;
    endsequence

    property p_reg_write;
        pop |=> regs_q[$past(f_out_data[FW-1:DW])] == $past(f_out_data[DW-1:0]);
    endproperty
    a_reg_write: assert property (p_reg_write) else $error("register not written");

    property p_byte_period;
        wr_byte |-> rise && bit_q == 3'h7;
    endproperty
    a_byte_period: assert property (p_byte_period) else $error("byte taken off period");

    property p_read_ignores_in;
        (st_q == SRA_ST_DATA && !dir_q) |-> !wr_byte;
    endproperty
    a_read_ignores_in: assert property (p_read_ignores_in) else $error("read byte stored");

    property p_read_load;
        s_hdr_read |=> left_q == 4'h8 && tx_q == regs_q[$past(rx_next[AW-1:0])];
    endproperty
    a_read_load: assert property (p_read_load) else $error("read fetch wrong");

    property p_shift;
        (shift_out && !load_rd) |=> serial_out_q == $past(tx_q[7]);
    endproperty
    a_shift: assert property (p_shift) else $error("bit not shifted out");

    property p_hold_d0;
        (sel_on && $past(sel_on) && left_q == 4'h0 && !fall) |=> $stable(serial_out_q);
    endproperty
    a_hold_d0: assert property (p_hold_d0) else $error("output moved after read");

    property p_release;
        !sel_on |=> !serial_out_oe_q && serial_out_q;
    endproperty
    a_release: assert property (p_release) else $error("output not released");

    property p_burst_inc;
        (data_end && sel_on) |=> addr_q == AW'($past(addr_q) + 1'b1);
    endproperty
    a_burst_inc: assert property (p_burst_inc) else $error("no address increment");

    property p_burst_capture;
        (data_end && dir_q && sel_on && f_in_ready) |-> wr_byte ##1 !wr_drop_q;
    endproperty
    a_burst_capture: assert property (p_burst_capture) else $error("burst byte lost");

    property p_shutdown;
        sdn_s |=> regs_q[0] == `SRA_REG_RESET && st_q == SRA_ST_IDLE && !serial_out_oe_q;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown not honoured");

    property p_msb_first;
        (rise && st_q == SRA_ST_HDR && sel_on) |=> rx_q == {$past(rx_q[6:0]), $past(sin_s)};
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("input not sampled");

endmodule // sra_slave

`default_nettype wire

// File: include/sra_defines.svh
/*
 * Constants of the serial register access slave: frame layout, register
 * space size, reset value and buffer depth.
 * Assumes it is included by bare name from the design and bench files.
 */
// Overview of operation
// - Frame: direction bit, seven address bits, byte
// - Address selects one of 128 byte registers
// - Direction one writes, direction zero reads
// - Byte captured as a unit every eight clocks
// - Read ignores serial input during data byte
// - Read data shifts out on falling edges
// - After read, output holds last bit D0; a clock parked low sends the next register's top bit instead
// - Select high releases output, pulled high
// - Burst continues with incremented address
// - Burst captures further bytes while select low
// - Shutdown loses registers and ignores transactions
`ifndef SRA_DEFINES_SVH
`define SRA_DEFINES_SVH

`define SRA_ADDR_W      7
`define SRA_DATA_W      8
`define SRA_REG_COUNT   128
`define SRA_REG_RESET   8'h00
`define SRA_BIT_LAST    3'h7
`define SRA_DIR_WRITE   1'b1
`define SRA_HDR_DIR_POS 7
`define SRA_FIFO_DEPTH  4
`define SRA_SCLK_MAX_HZ 10000000
`define SRA_SYS_HZ      20000000

`endif

// File: include/sra_pkg.sv
/*
 * Types shared by the serial register access slave.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package sra_pkg;

    // Frame sequencer states, one-hot
    typedef enum logic [2:0]
    {
        SRA_ST_IDLE = 3'b001,   // Select high or shut down
        SRA_ST_HDR  = 3'b010,   // Shifting direction and address
        SRA_ST_DATA = 3'b100    // Shifting data bytes, burst capable
    } sra_state_t;

endpackage

`default_nettype wire

// File: verification/sra_host_model.sv
/*
 * Host master model of the serial register port: select, clock and data.
 * Assumes clk_sys as its time base; sclk idles high between frames, so the
 * last rising edge of a frame is not followed by a falling edge.
 */
`default_nettype none

module sra_host_model
(
    input  wire logic clk_sys,     // Time base only
    input  wire logic line,        // Resolved serial_out pin
    output logic      sclk,        // Serial clock, still outside frames
    output logic      select_n,    // Frame select, active low
    output logic      serial_in    // Data towards the device
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle levels at time zero
    initial
    begin
        sclk      = 1'b1;
        select_n  = 1'b1;
        serial_in = 1'b0;
    end

    // Step n clocks, then move off the edge
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Drop select with margin for the synchroniser
    task automatic frame_open();
        select_n = 1'b0;
        wait_clk(4);
    endtask

    // Raise select; data line is then meaningless, so flip it
    task automatic frame_close();
        wait_clk(4);
        select_n  = 1'b1;
        serial_in = ~serial_in;
        wait_clk(6);
    endtask

    // One byte MSB first: data moves with the falling edge, the line is read
    // just before the rise; 4+4 clocks a bit gives 400 ns, far below the limit
    task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            serial_in = tx[i];
            sclk      = 1'b0;
            wait_clk(4);
            rx[i]     = line;       // Bit launched at this fall
            sclk      = 1'b1;
            wait_clk(4);
        end
    endtask
endmodule // sra_host_model

`default_nettype wire

// File: verification/sra_slave_test.sv
/*
 * Self-checking bench for sra_slave driven by the host model.
 * Assumes the package, defines and design files are compiled first.
 */
`include "sra_defines.svh"
`default_nettype none

`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fails++; \
    $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp); end end

module sra_slave_test;
    timeunit 1ns;
    timeprecision 100ps;

    logic       clk_sys;         // 20 MHz system clock
    logic       resetn;          // Synchronous reset, active low
    logic       shutdown;        // Power-off request
    logic       sclk;            // From the host model
    logic       select_n;        // From the host model
    logic       serial_in;       // From the host model
    logic       serial_out;      // Device data out
    logic       serial_out_oe;   // Device drives the pin
    logic       wr_drop;         // Lost write byte
    wire logic  line;            // Pin level seen by the host
    int         fails   = 0;     // Mismatch count
    int         checked = 0;     // Comparison count
    int         cycles  = 0;     // Watchdog count
    logic [7:0] shadow [128];    // Expected register contents

    // Pull-up holds the pin high when released
    assign line = serial_out_oe ? serial_out : 1'b1;

    sra_slave #(.FIFO_DEPTH(`SRA_FIFO_DEPTH)) uut
    (
        .clk_sys(clk_sys), .resetn(resetn), .shutdown(shutdown), .sclk(sclk),
        .select_n(select_n), .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .wr_drop(wr_drop)
    );

    sra_host_model host
    (
        .clk_sys(clk_sys), .line(line), .sclk(sclk), .select_n(select_n),
        .serial_in(serial_in)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Watchdog, ~2.8k cycles expected; buffer never fills at this link rate
    always @(posedge clk_sys)
    begin
        cycles++;
        if (resetn === 1'b1)
            `CHK(wr_drop, 1'b0)
        if (cycles == 20000)
        begin
            fails++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checked %0d, fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One frame: header then n bytes; reads send junk that must be ignored
    task automatic burst(input logic dir, input logic [6:0] addr, input int n,
                         input logic [7:0] base);
        logic [7:0] rx;
        logic [7:0] exp;
        logic [6:0] a;
        host.frame_open();
        host.shift_byte({dir, addr}, rx);
        `CHK(serial_out_oe, 1'b1)
        for (int i = 0; i < n; i++)
        begin
            a   = addr + 7'(i);   // Wraps after 127
            exp = dir ? base + 8'(i * 17) : shadow[a];
            host.shift_byte(dir ? exp : 8'hff, rx);
            if (dir == `SRA_DIR_WRITE)
                shadow[a] = exp;
            else
                `CHK(rx, exp)
        end
        if (!dir)
        begin
            host.wait_clk(8);
            `CHK(line, exp[0])
        end
        host.frame_close();
        `CHK(line, 1'b1)
        `CHK(serial_out_oe, 1'b0)
    endtask

    // Outputs released after reset, registers at reset value
    task automatic t_reset_state();
        `CHK(serial_out_oe, 1'b0)
        `CHK(line, 1'b1)
        burst(1'b0, 7'h00, 1, 8'h00);
        burst(1'b0, 7'h7f, 1, 8'h00);
        $display("test reset_state done");
    endtask

    // Single writes, then reads twice to show read junk did not land
    task automatic t_single();
        burst(1'b1, 7'h05, 1, 8'ha5);
        burst(1'b1, 7'h06, 1, 8'h3c);
        burst(1'b1, 7'h7f, 1, 8'h96);
        burst(1'b0, 7'h05, 2, 8'h00);
        burst(1'b0, 7'h05, 2, 8'h00);
        burst(1'b0, 7'h7f, 1, 8'h00);
        $display("test single done");
    endtask

    // Burst across the top of the address space
    task automatic t_burst();
        burst(1'b1, 7'h7d, 5, 8'h81);
        burst(1'b0, 7'h7b, 8, 8'h00);
        $display("test burst done");
    endtask

    // Shutdown clears registers and ignores a frame
    task automatic t_shutdown();
        logic [7:0] rx;
        burst(1'b1, 7'h21, 1, 8'h5a);
        shutdown = 1'b1;
        host.wait_clk(6);
        host.frame_open();
        host.shift_byte(8'ha1, rx);
        host.shift_byte(8'h77, rx);
        `CHK(serial_out_oe, 1'b0)
        `CHK(line, 1'b1)
        host.frame_close();
        shutdown = 1'b0;
        foreach (shadow[i]) shadow[i] = `SRA_REG_RESET;
        host.wait_clk(6);
        burst(1'b0, 7'h21, 1, 8'h00);
        $display("test shutdown done");
    endtask

    // Main sequence
    initial
    begin
        resetn   = 1'b0;
        shutdown = 1'b0;
        foreach (shadow[i]) shadow[i] = `SRA_REG_RESET;
        repeat (8) @(posedge clk_sys);
        #1;
        resetn = 1'b1;
        host.wait_clk(4);
        t_reset_state();
        t_single();
        t_burst();
        t_shutdown();
        final_report();
    end
endmodule // sra_slave_test

`default_nettype wire
